// >>> inc/mode_power_defs.svh
// Offsets, field positions, reset values and timing counts for the mode and power-state controller.
// Assumes inclusion by bare name from the design files.
`ifndef MODE_POWER_DEFS_SVH
`define MODE_POWER_DEFS_SVH

`define SYSTEM_CONTROL_ADDR 16'hFFC4
`define MODE_READBACK_ADDR 16'hFFC5
`define WAKE_CTRL_ADDR 16'hFFC6
`define PWR_STATUS_ADDR 16'hFFC7

`define SOFT_STANDBY_SELECT_BIT 7
`define SETTLE_SEL_HI_BIT 6
`define SETTLE_SEL_LO_BIT 4
`define SYSTEM_CONTROL_FIXED_ONE_BIT 3
`define NMI_EDGE_SELECT_BIT 2
`define DUAL_PORT_RAM_MODE_BIT 1
`define RAM_ENABLE_BIT 0

`define SYSTEM_CONTROL_RESET 8'h09
`define MODE_READBACK_FIXED 8'hE4

`define SETTLE_STATES_0 32'd8192
`define SETTLE_STATES_1 32'd16384
`define SETTLE_STATES_2 32'd32768
`define SETTLE_STATES_3 32'd65536
`define SETTLE_STATES_4 32'd131072

`define RESET_VECTOR_ADDR 16'h0000
`define RAM_LOW_ADDR 16'hF780
`define RAM_HIGH_ADDR 16'hFF7F
`define REG_FIELD_LOW_ADDR 16'hFF88
`define ROM_HIGH_LIMIT 16'hC000

`endif

// >>> inc/mode_power_pkg.sv
// Types shared by the mode and power-state controller.
// Assumes no other package.
package mode_power_pkg;

  typedef enum logic [1:0] {
    MODE_0,
    MODE_1,
    MODE_2,
    MODE_3
  } op_mode_e;

  typedef enum logic [2:0] {
    RUN,
    SLEEP,
    SOFT_STANDBY,
    SETTLE,
    HW_STANDBY,
    EXC_PUSH,
    EXC_VECTOR
  } power_state_e;

endpackage

// >>> rtl/mode_power_ctrl.sv
// Mode latch, system control registers, power-down sequencing and exception-entry handshake.
// Assumes a CPU core that reports sleep and instruction boundaries and performs the stack
// and vector bus cycles when asked; board pins arrive asynchronously.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "mode_power_defs.svh"

// Functional notes
// - SLEEP with standby select 0 halts CPU only; peripherals keep running.
// - SLEEP with standby select 1 halts all, resets peripherals, keeps RAM and ports.
// - Low standby pin halts everything including ports; peripherals reset, RAM kept.
// - Exception entry pushes PC and flags except on reset, masks, fetches vector.
// - Standby select stays 1 after interrupt wake until software clears it.
// - Interrupt wake from software standby idles for selected settling states.
// - System control bit 3 reads 1; writes ignored.
// - NMI edge select 0 means falling edge, 1 rising edge.
// - RAM enable bit gates RAM; reset sets it, software standby keeps it.
// - Expanded modes with RAM disabled send RAM-range accesses off-chip.
// - Mode pins latched at reset release; 01, 10, 11 select modes 1-3.
// - Modes 1 and 2 open a 64K external address space.
// - Mode 3 uses on-chip resources only; all ports general-purpose.
// - Mode readback low bits copy pins, captured at read time.
// - Mode readback bits 7-5 read 1, 4-3 read 0, bit 2 reads 1.
// - ROM-less variants run only in mode 1.
// - Reset release masks interrupts and loads PC from vector word 0.
// - Interrupt entry starts at instruction end or end of current sequence.
module mode_power_ctrl #(
  parameter logic HAS_ROM = 1'b1,
  parameter int SETTLE_SCALE = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mode_select_pin_hi,
  input wire logic mode_select_pin_lo,
  input wire logic hw_standby_pin_n,
  input wire logic nmi_pin_n,
  input wire logic sleep_exec,
  input wire logic insn_end,
  input wire logic irq_req,
  input wire logic ext_irq,
  input wire logic exc_step_done,
  input wire logic [15:0] cpu_addr,
  output logic cpu_halt,
  output logic periph_halt,
  output logic periph_reinit,
  output logic port_out_enable_n,
  output logic nmi_request,
  output logic exc_push_req,
  output logic exc_vector_req,
  output logic [15:0] exc_vector_addr,
  output logic set_int_mask,
  output logic [1:0] op_mode,
  output logic expanded_mode,
  output logic rom_enable,
  output logic ram_enable,
  output logic ram_select,
  output logic ext_select
);

  // Settle length in states for a select code; scale lets a simulation shrink it
  function automatic logic [31:0] settle_count(input logic [2:0] sel);
    logic [31:0] n;
    n = `SETTLE_STATES_0;
    case (sel)
      3'h0: n = `SETTLE_STATES_0;
      3'h1: n = `SETTLE_STATES_1;
      3'h2: n = `SETTLE_STATES_2;
      3'h3: n = `SETTLE_STATES_3;
      default: n = `SETTLE_STATES_4;
    endcase
    settle_count = n / 32'(SETTLE_SCALE);
  endfunction

  // On-chip RAM window decode
  function automatic logic in_ram_window(input logic [15:0] a);
    in_ram_window = (a >= `RAM_LOW_ADDR) && (a <= `RAM_HIGH_ADDR);
  endfunction

  logic [1:0] mode_pin_meta_reg;
  logic [1:0] mode_pin_sync_reg;
  logic [1:0] hw_standby_pin_sync_reg;
  logic [2:0] nmi_sync_reg;
  logic mode_latched_reg;
  logic [1:0] mode_reg;
  logic soft_standby_select_reg;
  logic [2:0] settle_sel_reg;
  logic nmi_edge_select_reg;
  logic dual_port_ram_mode_reg;
  logic ram_enable_bit_reg;
  logic [7:0] rdata_reg;
  logic [31:0] settle_cnt_reg;
  logic exc_is_reset_reg;
  logic nmi_request_reg;
  logic hw_standby_pin_low;
  mode_power_pkg::power_state_e state_reg;
  mode_power_pkg::power_state_e state_next;

  // Two-flop synchronisers for standby and NMI pins; reset values match idle pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hw_standby_pin_sync_reg <= 2'h3;
      nmi_sync_reg <= 3'h7;
    end else begin
      hw_standby_pin_sync_reg <= {hw_standby_pin_sync_reg[0], hw_standby_pin_n};
      nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin_n};
    end
  end

  // Mode straps keep syncing through reset
  // Latch then sees settled levels at release, not a reset value
  always_ff @(posedge clk) begin
    mode_pin_meta_reg <= {mode_select_pin_hi, mode_select_pin_lo};
    mode_pin_sync_reg <= mode_pin_meta_reg;
  end

  assign hw_standby_pin_low = !hw_standby_pin_sync_reg[1];

  // Mode caught once, on the first edge after reset release, after sync delay
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_latched_reg <= 1'b0;
      mode_reg <= 2'h1;
    end else if (!mode_latched_reg) begin
      mode_latched_reg <= 1'b1;
      // Without ROM only the expanded ROM-off mode exists
      mode_reg <= HAS_ROM ? mode_pin_sync_reg : 2'h1;
    end
  end

  // Mode decode; mode 0 is left undefined by the board, treated as mode 1
  assign op_mode = mode_reg;
  assign expanded_mode = (mode_reg != 2'h3);
  assign rom_enable = HAS_ROM && (mode_reg[1] == 1'b1);
  assign ram_enable = ram_enable_bit_reg;
  assign ram_select = ram_enable_bit_reg && in_ram_window(cpu_addr);
  // RAM window falls through to the external bus when disabled, expanded modes only
  // Register field at the top and enabled ROM at the bottom never go off-chip
  assign ext_select = expanded_mode && !ram_select && (cpu_addr < `REG_FIELD_LOW_ADDR) &&
                      !(rom_enable && (cpu_addr < `ROM_HIGH_LIMIT));

  // System control writes; reserved and fixed bits never stored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      soft_standby_select_reg <= 1'b0;
      settle_sel_reg <= 3'h0;
      nmi_edge_select_reg <= 1'b0;
      dual_port_ram_mode_reg <= 1'b0;
      ram_enable_bit_reg <= 1'b1;
    end else if (reg_wr && reg_addr == `SYSTEM_CONTROL_ADDR) begin
      // Standby select is cleared only by reset or this write, never by wake-up
      soft_standby_select_reg <= reg_wdata[`SOFT_STANDBY_SELECT_BIT];
      settle_sel_reg <= reg_wdata[`SETTLE_SEL_HI_BIT:`SETTLE_SEL_LO_BIT];
      nmi_edge_select_reg <= reg_wdata[`NMI_EDGE_SELECT_BIT];
      // Kept as storage only; software is expected to leave it 0
      dual_port_ram_mode_reg <= reg_wdata[`DUAL_PORT_RAM_MODE_BIT];
      ram_enable_bit_reg <= reg_wdata[`RAM_ENABLE_BIT];
    end
  end

  // Read data one cycle later; mode bits copy the pins at read time
  // Pin copy lags the pin by the two sync stages, harmless for static straps
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SYSTEM_CONTROL_ADDR: rdata_reg <= {soft_standby_select_reg, settle_sel_reg, 1'b1,
                                            nmi_edge_select_reg, dual_port_ram_mode_reg, ram_enable_bit_reg};
        `MODE_READBACK_ADDR: rdata_reg <= `MODE_READBACK_FIXED | {6'h00, mode_pin_sync_reg};
        `PWR_STATUS_ADDR: rdata_reg <= {5'h00, state_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // NMI edge detect on the synchronised level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmi_request_reg <= 1'b0;
    end else begin
      nmi_request_reg <= nmi_edge_select_reg ? (nmi_sync_reg[1] && !nmi_sync_reg[2])
                                             : (!nmi_sync_reg[1] && nmi_sync_reg[2]);
    end
  end

  assign nmi_request = nmi_request_reg;

  // Power and exception state transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mode_power_pkg::RUN: begin
        if (sleep_exec && soft_standby_select_reg) begin
          state_next = mode_power_pkg::SOFT_STANDBY;
        end else if (sleep_exec) begin
          state_next = mode_power_pkg::SLEEP;
        end else if ((irq_req || nmi_request_reg) && insn_end) begin
          state_next = mode_power_pkg::EXC_PUSH;
        end
      end
      mode_power_pkg::SLEEP: begin
        if (irq_req || nmi_request_reg) begin
          state_next = mode_power_pkg::EXC_PUSH;
        end
      end
      mode_power_pkg::SOFT_STANDBY: begin
        if (ext_irq || nmi_request_reg) begin
          state_next = mode_power_pkg::SETTLE;
        end
      end
      mode_power_pkg::SETTLE: begin
        if (settle_cnt_reg <= 32'd1) begin
          state_next = mode_power_pkg::EXC_PUSH;
        end
      end
      mode_power_pkg::EXC_PUSH: begin
        if (exc_is_reset_reg || exc_step_done) begin
          state_next = mode_power_pkg::EXC_VECTOR;
        end
      end
      mode_power_pkg::EXC_VECTOR: begin
        if (exc_step_done) begin
          state_next = mode_power_pkg::RUN;
        end
      end
      mode_power_pkg::HW_STANDBY: begin
        state_next = mode_power_pkg::HW_STANDBY;
      end
      default: state_next = mode_power_pkg::RUN;
    endcase
    // Standby pin overrides everything
    if (hw_standby_pin_low) begin
      state_next = mode_power_pkg::HW_STANDBY;
    end
  end

  // State register; reset release enters the vector fetch without a push
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= mode_power_pkg::EXC_PUSH;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset flag skips the stack push for the first sequence only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      exc_is_reset_reg <= 1'b1;
    end else if (state_reg == mode_power_pkg::EXC_VECTOR && exc_step_done) begin
      exc_is_reset_reg <= 1'b0;
    end
  end

  // Settling counter loaded on wake; select sampled at the wake moment
  // Limitation: a scale above 1 shortens the settle, for simulation only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      settle_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == mode_power_pkg::SOFT_STANDBY) begin
      settle_cnt_reg <= settle_count(settle_sel_reg);
    end else if (state_reg == mode_power_pkg::SETTLE && settle_cnt_reg != 32'h0000_0000) begin
      settle_cnt_reg <= settle_cnt_reg - 32'd1;
    end
  end

  // Halt and reinit levels by state
  // Ports keep levels in software standby, float in hardware standby
  always_comb begin
    cpu_halt = 1'b0;
    periph_halt = 1'b0;
    periph_reinit = 1'b0;
    port_out_enable_n = 1'b0;
    case (state_reg)
      mode_power_pkg::SLEEP: begin
        // Peripherals keep running, only the core waits
        cpu_halt = 1'b1;
      end
      mode_power_pkg::SOFT_STANDBY: begin
        cpu_halt = 1'b1;
        periph_halt = 1'b1;
        periph_reinit = 1'b1;
      end
      mode_power_pkg::SETTLE: begin
        // Clock still settling; reinit was held through software standby
        cpu_halt = 1'b1;
        periph_halt = 1'b1;
      end
      mode_power_pkg::HW_STANDBY: begin
        cpu_halt = 1'b1;
        periph_halt = 1'b1;
        periph_reinit = 1'b1;
        port_out_enable_n = 1'b1;
      end
      default: begin
        cpu_halt = 1'b0;
      end
    endcase
  end

  // Exception-entry handshake to the core; the reset sequence skips the push
  always_comb begin
    exc_push_req = 1'b0;
    exc_vector_req = 1'b0;
    set_int_mask = 1'b0;
    case (state_reg)
      mode_power_pkg::EXC_PUSH: begin
        exc_push_req = !exc_is_reset_reg;
      end
      mode_power_pkg::EXC_VECTOR: begin
        // Mask raised while the vector is fetched
        exc_vector_req = 1'b1;
        set_int_mask = 1'b1;
      end
      default: begin
        exc_push_req = 1'b0;
      end
    endcase
  end

  // Only the reset vector is fixed here; the core indexes interrupt vectors itself
  assign exc_vector_addr = `RESET_VECTOR_ADDR;

endmodule

// >>> sim/board_pins.sv
// Board model for mode straps, standby input and NMI line.
// Assumes the bench sets the strap value before reset ends.
`timescale 1ns/1ns
module board_pins (
  input wire logic [1:0] mode_cfg,
  input wire logic hw_standby_pin_on,
  input wire logic nmi_lvl,
  output logic mode_select_pin_hi,
  output logic mode_select_pin_lo,
  output logic hw_standby_pin_n,
  output logic nmi_pin_n
);
  // Straps never show mode 0 and stay put while running
  assign mode_select_pin_hi = mode_cfg[1];
  assign mode_select_pin_lo = mode_cfg[0] | ~mode_cfg[1];
  assign hw_standby_pin_n = ~hw_standby_pin_on;
  assign nmi_pin_n = nmi_lvl;
endmodule

// >>> sim/mode_and_power_state_control_tb_top.sv
// Self-checking bench for the mode and power-state controller.
// Assumes board_pins partner; settle base of 8 cycles at scale 1024.
`timescale 1ns/1ns
module mode_and_power_state_control_tb_top;
  logic clk, rst_b, wr, rd, slp, ie, irq, xirq, done, hw_standby_pin, nmi;
  logic ph, pl, sn, nn, halt, phalt, rinit, poe, nreq, preq, vreq, imask, exs;
  logic [15:0] addr, ca, vaddr;
  logic [7:0] wd, rdata, v, r;
  logic [1:0] m, om;
  logic exm, rom, ren, rsel;
  int num_errors = 0, tests_run = 0, nmi_cnt = 0, c, i, s;
  int seed = 32'h8abba8c1;
  mode_power_ctrl #(.SETTLE_SCALE(1024)) u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .mode_select_pin_hi(ph), .mode_select_pin_lo(pl),
    .hw_standby_pin_n(sn), .nmi_pin_n(nn), .sleep_exec(slp), .insn_end(ie), .irq_req(irq), .ext_irq(xirq),
    .exc_step_done(done), .cpu_addr(ca), .cpu_halt(halt), .periph_halt(phalt), .periph_reinit(rinit),
    .port_out_enable_n(poe), .nmi_request(nreq), .exc_push_req(preq), .exc_vector_req(vreq),
    .exc_vector_addr(vaddr), .set_int_mask(imask), .op_mode(om), .expanded_mode(exm), .rom_enable(rom),
    .ram_enable(ren), .ram_select(rsel), .ext_select(exs));
  board_pins u_pins (.mode_cfg(m), .hw_standby_pin_on(hw_standby_pin), .nmi_lvl(nmi), .mode_select_pin_hi(ph),
    .mode_select_pin_lo(pl), .hw_standby_pin_n(sn), .nmi_pin_n(nn));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  // Read data is taken only in the slot after the strobe
  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic wait_push(output int n);
    for (n = 0; n < 300 && preq !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({vreq, imask, vaddr}, {2'b11, 16'h0000});
    steps(1);
    rreg(16'hFFC4, v);
    chk(v, 8'h09);
  endtask
  task automatic sleep_cmd;
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (nreq === 1'b1) nmi_cnt++;
  // Hang guard, well past the longest settle loop
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
  initial begin
    {rst_b, wr, rd, slp, ie, irq, xirq, done, hw_standby_pin, addr, wd, ca} = '0;
    nmi = 1'b1;
    m = 2'(1 + $unsigned($random(seed)) % 3);
    do_reset;
    chk(om, m);
    chk({exm, rom, ren}, {m != 2'd3, m != 2'd1, 1'b1});
    rreg(16'hFFC5, v);
    chk(v, {6'h39, m});
    wreg(16'hFFC5, 8'h1B);
    rreg(16'hFFC5, v);
    chk(v, {6'h39, m});
    rreg(16'hFFC6, v);
    chk(v, 8'h00);
    // Dual-port bit always written 0
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed)) & 8'h75;
      wreg(16'hFFC4, v);
      rreg(16'hFFC4, r);
      chk(r, v | 8'h08);
    end
    wreg(16'hFFC4, 8'h08);
    @(posedge clk) ca <= 16'hF780 + 16'($random(seed) & 16'h07FF);
    #1 chk(exs, m != 2'd3);
    chk({ren, rsel}, 2'b00);
    $display("test registers done");
    for (s = 0; s < 2; s++) begin
      wreg(16'hFFC4, 8'h09 | 8'(s << 2));
      @(posedge clk) nmi <= ~s[0];
      repeat (6) @(posedge clk);
      c = nmi_cnt;
      @(posedge clk) nmi <= s[0];
      repeat (6) @(posedge clk);
      chk(nmi_cnt - c, 1);
      @(posedge clk) nmi <= ~s[0];
      repeat (6) @(posedge clk);
      chk(nmi_cnt - c, 1);
    end
    $display("test nmi done");
    @(posedge clk) irq <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(preq, 1'b0);
    @(posedge clk) ie <= 1'b1;
    @(posedge clk) ie <= 1'b0;
    #1 chk(preq, 1'b1);
    @(posedge clk) irq <= 1'b0;
    steps(1);
    #1 chk({preq, vreq, imask}, 3'b011);
    steps(1);
    #1 chk(vreq, 1'b0);
    wreg(16'hFFC4, 8'h09);
    sleep_cmd;
    #1 chk({halt, phalt, rinit, poe}, 4'b1000);
    @(posedge clk) irq <= 1'b1;
    wait_push(c);
    chk(preq, 1'b1);
    @(posedge clk) irq <= 1'b0;
    steps(2);
    $display("test sleep done");
    // Settle codes 0 to 4, random RAM enable kept across standby
    for (s = 0; s < 5; s++) begin
      v = 8'h88 | 8'(s << 4) | 8'($random(seed) & 1);
      wreg(16'hFFC4, v);
      sleep_cmd;
      #1 chk({halt, phalt, rinit, poe}, 4'b1110);
      @(posedge clk) xirq <= 1'b1;
      wait_push(c);
      chk(c >= (8 << s) - 1 && c <= (8 << s) + 4, 1);
      @(posedge clk) xirq <= 1'b0;
      steps(2);
      rreg(16'hFFC4, r);
      chk(r, v);
    end
    $display("test standby done");
    @(posedge clk) hw_standby_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({halt, phalt, rinit, poe}, 4'b1111);
    @(posedge clk) hw_standby_pin <= 1'b0;
    do_reset;
    $display("test hw standby done");
    print_verdict;
  end
endmodule

// >>> sim/mode_power_monitor.sv
// Port checker for the mode and power-state controller.
// Assumes binding to mode_power_ctrl with static mode pins.
`timescale 1ns/1ns
module mode_power_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic mode_select_pin_hi,
  input wire logic mode_select_pin_lo,
  input wire logic insn_end,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_halt,
  input wire logic periph_halt,
  input wire logic periph_reinit,
  input wire logic port_out_enable_n,
  input wire logic exc_push_req,
  input wire logic exc_vector_req,
  input wire logic [15:0] exc_vector_addr,
  input wire logic set_int_mask,
  input wire logic [1:0] op_mode,
  input wire logic expanded_mode,
  input wire logic ram_enable,
  input wire logic ram_select,
  input wire logic ext_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Read data tied to the read slot
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_fixed_one: assert property ($past(reg_rd) && $past(reg_addr) == 16'hFFC4 |-> reg_rdata[3])
    else $error("system control bit 3 low");
  a_mode_fixed: assert property ($past(reg_rd) && $past(reg_addr) == 16'hFFC5 |-> reg_rdata[7:2] == 6'h39)
    else $error("mode readback fixed bits wrong");
  a_mode_pins: assert property ($past(reg_rd) && $past(reg_addr) == 16'hFFC5 |->
    reg_rdata[1:0] == {$past(mode_select_pin_hi), $past(mode_select_pin_lo)})
    else $error("mode readback pins wrong");
  // Halt levels must nest: ports off implies everything off
  a_sleep_only: assert property (cpu_halt && !periph_halt |-> !periph_reinit && !port_out_enable_n)
    else $error("sleep disturbs peripherals");
  a_soft_halt: assert property (periph_halt |-> cpu_halt)
    else $error("peripherals halted alone");
  a_hw_standby: assert property (port_out_enable_n |-> cpu_halt && periph_halt && periph_reinit)
    else $error("ports off without full halt");
  a_exc_vector: assert property (exc_vector_req |-> set_int_mask && exc_vector_addr == 16'h0000)
    else $error("vector fetch without mask");
  a_push_boundary: assert property ($rose(exc_push_req) && !$past(cpu_halt) |-> $past(insn_end))
    else $error("push off instruction boundary");
  a_ram_route: assert property (expanded_mode && !ram_enable && cpu_addr inside {[16'hF780:16'hFF7F]}
    |-> ext_select && !ram_select)
    else $error("disabled RAM not routed off-chip");
  a_single_chip: assert property (op_mode == 2'b11 |-> !expanded_mode && !ext_select)
    else $error("single-chip mode expanded");
  c_settle: cover property (periph_halt ##1 !periph_halt);
  c_vector: cover property ($rose(exc_vector_req));
  c_hw: cover property (port_out_enable_n);
endmodule

bind mode_power_ctrl mode_power_monitor u_mon (.*);
